// ===== design/acc_conv_ctrl.sv
// Converter control top: AXI4-Lite registers, start/abort sequencing,
// successive approximation register and result formatting.
// Assumes the analog core samples while sample_hold is high and returns
// the comparator decision for trial_word on cmp_high.
`timescale 1ns/1ps
module acc_conv_ctrl (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Compare unit and timer
    input  wire logic        special_event_trigger,
    output logic             timer_one_reset,
    // Analog core
    input  wire logic        cmp_high,
    input  wire logic        rc_half_tick,
    output logic             conv_enable,
    output logic             sample_hold,
    output logic [9:0]       trial_word,
    output logic [4:0]       chan_code,
    output logic             chan_connect,
    output logic [2:0]       ref_pos_onehot,
    output logic             ref_neg_pin,
    output logic             done_flag
);
    acc_pkg::acc_state_t st_reg;
    logic       go_reg;
    logic [4:0] chs_reg;
    logic       just_reg;
    logic [2:0] cs_reg;
    logic       nref_reg;
    logic [1:0] pref_reg;
    logic [7:0] res_hi_reg;
    logic [7:0] res_lo_reg;
    logic       cur_just_reg;
    logic [2:0] cur_cs_reg;
    logic [3:0] idx_reg;
    logic       last_bit_reg;
    logic [4:0] halves_reg;
    logic       aw_have_reg;
    logic       w_have_reg;
    logic [7:0] aw_addr_reg;
    logic [7:0] w_data_reg;
    logic       w_lane0_reg;
    logic       half_tick;
    logic       wr_fire;
    logic       wr_ctrl0;
    logic       trig_go;
    logic       start;
    logic       turn_off;
    logic       abort;
    logic       decide;
    logic       finish;
    logic [4:0] ch_now;
    logic [7:0] rd_byte;

    acc_tad_gen u_tad (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .run          (st_reg != acc_pkg::ST_IDLE),
        .sel          (cur_cs_reg),
        .rc_half_tick (rc_half_tick),
        .half_tick    (half_tick)
    );

    // Write completes once both address and data are held and byte lane 0 was strobed
    assign wr_fire  = aw_have_reg && w_have_reg && !s_axi_bvalid &&
                      w_lane0_reg;
    assign wr_ctrl0 = wr_fire && (aw_addr_reg == acc_pkg::OFF_CTRL0);
    assign trig_go  = special_event_trigger && conv_enable;
    assign start    = (st_reg == acc_pkg::ST_IDLE) &&
                      (trig_go || (wr_ctrl0 &&
                       w_data_reg[acc_pkg::GO_BIT] &&
                       w_data_reg[acc_pkg::ON_BIT]));
    assign turn_off = wr_ctrl0 && !w_data_reg[acc_pkg::ON_BIT];
    // A trigger in the same cycle wins over a software clear
    assign abort    = wr_ctrl0 && !w_data_reg[acc_pkg::GO_BIT] &&
                      (st_reg != acc_pkg::ST_IDLE) && !trig_go;
    assign decide   = (st_reg == acc_pkg::ST_CONVERT) && half_tick &&
                      !halves_reg[0];
    // Only a write that stops or aborts may suppress the final load
    assign finish   = decide && (idx_reg == 4'h0) && !turn_off && !abort;
    assign ch_now   = wr_ctrl0 ?
                      w_data_reg[acc_pkg::CHS_LSB +: acc_pkg::CHS_W] :
                      chs_reg;

    // Write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= acc_pkg::RESP_OKAY;
            aw_have_reg   <= 1'b0;
            w_have_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 8'h00;
            w_lane0_reg   <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_reg   <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (!aw_have_reg && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_reg   <= 1'b1;
                w_data_reg   <= s_axi_wdata[7:0];
                w_lane0_reg  <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end else if (!w_have_reg && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
                aw_have_reg  <= 1'b0;
                w_have_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= acc_pkg::is_mapped(aw_addr_reg) ?
                                acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read mux; bit 7 of control zero and bit 3 of config read as zero
    always_comb begin
        if (s_axi_araddr == acc_pkg::OFF_CTRL0) begin
            rd_byte = {1'b0, chs_reg, go_reg, conv_enable};
        end else if (s_axi_araddr == acc_pkg::OFF_CFG1) begin
            rd_byte = {just_reg, cs_reg, 1'b0, nref_reg, pref_reg};
        end else if (s_axi_araddr == acc_pkg::OFF_RES_HI) begin
            rd_byte = res_hi_reg;
        end else if (s_axi_araddr == acc_pkg::OFF_RES_LO) begin
            rd_byte = res_lo_reg;
        end else if (s_axi_araddr == acc_pkg::OFF_STATUS) begin
            rd_byte = {7'h00, done_flag};
        end else begin
            rd_byte = 8'h00;
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= acc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= acc_pkg::is_mapped(s_axi_araddr) ?
                             acc_pkg::RESP_OKAY : acc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Software configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv_enable <= acc_pkg::CTRL0_RESET[acc_pkg::ON_BIT];
            chs_reg     <= acc_pkg::CTRL0_RESET[acc_pkg::CHS_LSB +: 5];
            just_reg    <= acc_pkg::CFG1_RESET[acc_pkg::JUST_BIT];
            cs_reg      <= acc_pkg::CFG1_RESET[acc_pkg::CS_LSB +: 3];
            nref_reg    <= acc_pkg::CFG1_RESET[acc_pkg::NREF_BIT];
            pref_reg    <= acc_pkg::CFG1_RESET[acc_pkg::PREF_LSB +: 2];
        end else begin
            if (wr_ctrl0) begin
                conv_enable <= w_data_reg[acc_pkg::ON_BIT];
                chs_reg     <= w_data_reg[acc_pkg::CHS_LSB +: 5];
            end
            if (wr_fire && aw_addr_reg == acc_pkg::OFF_CFG1) begin
                just_reg <= w_data_reg[acc_pkg::JUST_BIT];
                cs_reg   <= w_data_reg[acc_pkg::CS_LSB +: 3];
                nref_reg <= w_data_reg[acc_pkg::NREF_BIT];
                pref_reg <= w_data_reg[acc_pkg::PREF_LSB +: 2];
            end
        end
    end

    // Analog selections follow software while idle so acquisition can
    // settle before the start, and freeze while converting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chan_code      <= 5'h00;
            chan_connect   <= 1'b0;
            ref_pos_onehot <= acc_pkg::POS_SUPPLY;
            ref_neg_pin    <= 1'b0;
        end else if (st_reg == acc_pkg::ST_IDLE) begin
            chan_code    <= ch_now;
            chan_connect <= (ch_now <= acc_pkg::CH_LAST_PIN) ||
                            (ch_now >= acc_pkg::CH_TEMP);
            ref_neg_pin  <= nref_reg;
            // Reserved code falls back to the supply, the safe choice
            if (pref_reg == acc_pkg::PREF_PIN) begin
                ref_pos_onehot <= acc_pkg::POS_PIN;
            end else if (pref_reg == acc_pkg::PREF_FIXED) begin
                ref_pos_onehot <= acc_pkg::POS_FIXED;
            end else begin
                ref_pos_onehot <= acc_pkg::POS_SUPPLY;
            end
        end
    end

    // Sequencer and successive approximation register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg       <= acc_pkg::ST_IDLE;
            go_reg       <= 1'b0;
            sample_hold  <= 1'b0;
            halves_reg   <= 5'h00;
            idx_reg      <= 4'h0;
            trial_word   <= 10'h000;
            last_bit_reg <= 1'b0;
            cur_just_reg <= 1'b0;
            cur_cs_reg   <= 3'h0;
        end else if (turn_off || abort) begin
            st_reg      <= acc_pkg::ST_IDLE;
            go_reg      <= 1'b0;
            sample_hold <= 1'b0;
        end else if (start) begin
            st_reg       <= acc_pkg::ST_SAMPLE;
            go_reg       <= 1'b1;
            sample_hold  <= 1'b1;
            halves_reg   <= 5'h00;
            idx_reg      <= acc_pkg::TOP_BIT;
            trial_word   <= acc_pkg::FIRST_TRIAL;
            last_bit_reg <= 1'b0;
            cur_just_reg <= just_reg;
            cur_cs_reg   <= cs_reg;
        end else if (half_tick) begin
            halves_reg <= halves_reg + 5'h01;
            case (st_reg)
                acc_pkg::ST_SAMPLE: begin
                    if (halves_reg == acc_pkg::SAMPLE_LAST) begin
                        st_reg      <= acc_pkg::ST_CONVERT;
                        sample_hold <= 1'b0;
                    end
                end
                acc_pkg::ST_CONVERT: begin
                    if (!halves_reg[0]) begin
                        trial_word[idx_reg] <= cmp_high;
                        last_bit_reg        <= cmp_high;
                        if (idx_reg == 4'h0) begin
                            st_reg <= acc_pkg::ST_IDLE;
                            go_reg <= 1'b0;
                        end else begin
                            trial_word[idx_reg - 4'h1] <= 1'b1;
                            idx_reg <= idx_reg - 4'h1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Results: hardware loads win over software writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_hi_reg <= acc_pkg::RES_RESET;
            res_lo_reg <= acc_pkg::RES_RESET;
        end else if (finish) begin
            {res_hi_reg, res_lo_reg} <= acc_pkg::fmt(
                acc_pkg::fill_low(trial_word, 4'h0, cmp_high),
                cur_just_reg);
        end else if (abort && !turn_off) begin
            {res_hi_reg, res_lo_reg} <= acc_pkg::fmt(
                acc_pkg::fill_low(trial_word, idx_reg, last_bit_reg),
                cur_just_reg);
        end else if (wr_fire) begin
            if (aw_addr_reg == acc_pkg::OFF_RES_HI) begin
                res_hi_reg <= w_data_reg;
            end
            if (aw_addr_reg == acc_pkg::OFF_RES_LO) begin
                res_lo_reg <= w_data_reg;
            end
        end
    end

    // Done flag: a completion in the clearing cycle still sets it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_flag       <= 1'b0;
            timer_one_reset <= 1'b0;
        end else begin
            done_flag <= finish || (done_flag && !(wr_fire &&
                         aw_addr_reg == acc_pkg::OFF_STATUS &&
                         w_data_reg[acc_pkg::DONE_BIT]));
            timer_one_reset <= special_event_trigger;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_hw_start;
        trig_go && st_reg == acc_pkg::ST_IDLE && !turn_off
            |=> go_reg && sample_hold;
    endproperty
    a_hw_start: assert property (p_hw_start)
        else $error("trigger did not start a conversion");

    property p_timer_reset;
        special_event_trigger |=> timer_one_reset ##1
            (timer_one_reset == $past(special_event_trigger));
    endproperty
    a_timer_reset: assert property (p_timer_reset)
        else $error("timer reset pulse does not follow trigger");

    property p_busy_state;
        go_reg == (st_reg != acc_pkg::ST_IDLE);
    endproperty
    a_busy_state: assert property (p_busy_state)
        else $error("busy flag disagrees with sequencer");

    property p_complete;
        finish |=> !go_reg && done_flag;
    endproperty
    a_complete: assert property (p_complete)
        else $error("completion did not clear busy and set done");

    property p_off_idle;
        !conv_enable |-> st_reg == acc_pkg::ST_IDLE;
    endproperty
    a_off_idle: assert property (p_off_idle)
        else $error("converting while disabled");

    property p_no_channel;
        chan_code > acc_pkg::CH_LAST_PIN && chan_code < acc_pkg::CH_TEMP
            |-> !chan_connect;
    endproperty
    a_no_channel: assert property (p_no_channel)
        else $error("reserved channel connected");

    property p_right_just;
        finish && cur_just_reg |=> res_hi_reg[7:2] == 6'h00;
    endproperty
    a_right_just: assert property (p_right_just)
        else $error("right justified high bits not zero");

    property p_left_just;
        finish && !cur_just_reg |=> res_lo_reg[5:0] == 6'h00 &&
            res_hi_reg == $past(trial_word[9:2]);
    endproperty
    a_left_just: assert property (p_left_just)
        else $error("left justified layout wrong");

    property p_latched;
        st_reg != acc_pkg::ST_IDLE && !start ##1 st_reg != acc_pkg::ST_IDLE
            |-> $stable(cur_cs_reg) && $stable(chan_code);
    endproperty
    a_latched: assert property (p_latched)
        else $error("selection changed during conversion");

    property p_length;
        finish |-> halves_reg == acc_pkg::CONV_LAST;
    endproperty
    a_length: assert property (p_length)
        else $error("conversion not 23 half bit periods");

    property p_abort;
        abort |=> !go_reg && !sample_hold &&
            st_reg == acc_pkg::ST_IDLE;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort did not stop conversion");
endmodule // acc_conv_ctrl

// ===== design/acc_pkg.sv
// Constants, types and helpers shared by the converter control block.
// Assumes a 125 MHz aclk and a 32-bit AXI4-Lite register bus.
// Contract
// - Compare trigger sets the busy flag by hardware
// - Compare trigger also zeroes the timer counter
// - Channel codes 0 to 13 select pins
// - Codes 14 to 28 connect no channel
// - Codes 29-31: temperature, DAC, fixed reference
// - Writing one starts; cleared automatically at completion
// - Busy flag zero means idle or finished
// - Enable bit powers converter; off stops everything
// - Right justify zeroes six top high bits
// - Left justify zeroes six low bits
// - Clock select codes pick divider or RC
// - Negative reference: ground or external pin
// - Positive reference: supply, pin, fixed; 01 reserved
// - Left format: high holds 9-2, low 1-0
// - Unimplemented control bits read zero, ignore writes
// - Completion clears busy, sets done, loads results
// - Software abort loads partial, fills with last bit
// - Full conversion takes 11.5 bit periods
package acc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL0  = 8'h00;
    localparam logic [7:0] OFF_CFG1   = 8'h04;
    localparam logic [7:0] OFF_RES_HI = 8'h08;
    localparam logic [7:0] OFF_RES_LO = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;

    // Field positions
    localparam int ON_BIT   = 0;
    localparam int GO_BIT   = 1;
    localparam int CHS_LSB  = 2;
    localparam int CHS_W    = 5;
    localparam int PREF_LSB = 0;
    localparam int NREF_BIT = 2;
    localparam int CS_LSB   = 4;
    localparam int JUST_BIT = 7;
    localparam int DONE_BIT = 0;

    // Reset values
    localparam logic [7:0] CTRL0_RESET = 8'h00;
    localparam logic [7:0] CFG1_RESET  = 8'h00;
    localparam logic [7:0] RES_RESET   = 8'h00;

    // Channel codes
    localparam logic [4:0] CH_LAST_PIN = 5'h0D;
    localparam logic [4:0] CH_TEMP     = 5'h1D;
    localparam logic [4:0] CH_DAC      = 5'h1E;
    localparam logic [4:0] CH_FIXED    = 5'h1F;

    // Positive reference codes and one-hot outputs
    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_PIN    = 2'h2;
    localparam logic [1:0] PREF_FIXED  = 2'h3;
    localparam logic [2:0] POS_SUPPLY  = 3'h1;
    localparam logic [2:0] POS_PIN     = 3'h2;
    localparam logic [2:0] POS_FIXED   = 3'h4;

    // Conversion timing in half bit periods: 11.5 periods is 23 halves
    localparam int         HALF_TADS   = 23;
    localparam logic [4:0] SAMPLE_LAST = 5'h02;
    localparam logic [4:0] CONV_LAST   = 5'(HALF_TADS - 1);
    localparam logic [3:0] TOP_BIT     = 4'h9;
    localparam logic [9:0] FIRST_TRIAL = 10'h200;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b100
    } acc_state_t;

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == OFF_CTRL0) || (a == OFF_CFG1) || (a == OFF_RES_HI) ||
               (a == OFF_RES_LO) || (a == OFF_STATUS);
    endfunction

    // Half bit period length minus one, in aclk cycles
    function automatic logic [4:0] half_limit(input logic [2:0] sel);
        case (sel)
            3'h0:    return 5'h00;
            3'h4:    return 5'h01;
            3'h1:    return 5'h03;
            3'h5:    return 5'h07;
            3'h2:    return 5'h0F;
            default: return 5'h1F;
        endcase
    endfunction

    // Bits at and below idx take the value b
    function automatic logic [9:0] fill_low(input logic [9:0] w,
                                            input logic [3:0] idx,
                                            input logic       b);
        logic [9:0] r;
        r = w;
        for (int i = 0; i < 10; i++) begin
            if (i <= int'(idx)) begin
                r[i] = b;
            end
        end
        return r;
    endfunction

    // Returns {high byte, low byte}
    function automatic logic [15:0] fmt(input logic [9:0] v,
                                        input logic       rj);
        if (rj) begin
            return {6'h00, v};
        end
        return {v, 6'h00};
    endfunction

endpackage

// ===== design/acc_tad_gen.sv
// Half bit period enable generator for the converter sequencer.
// Assumes rc_half_tick is a one-cycle pulse synchronous to aclk.
`timescale 1ns/1ps
module acc_tad_gen (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] sel,
    input  wire logic       rc_half_tick,
    // Enable out
    output logic            half_tick
);
    logic [4:0] cnt_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_reg   <= 5'h00;
            half_tick <= 1'b0;
        end else if (sel[1:0] == 2'h3) begin
            half_tick <= rc_half_tick;
        end else if (cnt_reg == acc_pkg::half_limit(sel)) begin
            cnt_reg   <= 5'h00;
            half_tick <= 1'b1;
        end else begin
            cnt_reg   <= cnt_reg + 5'h01;
            half_tick <= 1'b0;
        end
    end
endmodule // acc_tad_gen

// ===== tb/acc_analog_model.sv
// Behavioural sample-and-hold and comparator facing the control block.
// Assumes cmp_high means the held input is at or above trial_word.
`timescale 1ns/1ps
module acc_analog_model (
    // Clock
    input  wire logic       aclk,
    // From the control block
    input  wire logic       conv_enable,
    input  wire logic       sample_hold,
    input  wire logic [9:0] trial_word,
    // Analog input level from the bench
    input  wire logic [9:0] level,
    // Decision
    output logic            cmp_high
);
    logic [9:0] held;

    // Input is frozen once sampling ends, as the real hold capacitor is
    always_ff @(posedge aclk) begin
        if (sample_hold) begin
            held <= level;
        end
    end

    assign cmp_high = conv_enable && (trial_word <= held);
endmodule // acc_analog_model

// ===== tb/tb_top.sv
// Register-level bench for the converter control block.
// Assumes the analog model in acc_analog_model answers each trial word.
`timescale 1ns/1ps
module tb_top;
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, rc_half_tick = 0;
    logic        special_event_trigger = 0, cmp_high, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        timer_one_reset, conv_enable, sample_hold, chan_connect;
    logic        ref_neg_pin, done_flag;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [9:0]  trial_word, level = 0;
    logic [4:0]  chan_code;
    logic [2:0]  ref_pos_onehot, rc_cnt = 0;
    int          n_mismatch = 0, total_checks = 0;

    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        rc_cnt <= rc_cnt + 3'h1;
        rc_half_tick <= (rc_cnt == 3'h7);
    end
    acc_conv_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .special_event_trigger,
        .timer_one_reset, .cmp_high, .rc_half_tick, .conv_enable,
        .sample_hold, .trial_word, .chan_code, .chan_connect,
        .ref_pos_onehot, .ref_neg_pin, .done_flag);
    acc_analog_model i_core (.aclk, .conv_enable, .sample_hold,
        .trial_word, .level, .cmp_high);

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", s, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0;
        rr = s_axi_bresp;
        if (n == 100) begin n_mismatch++; stop_test; end
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        if (n == 100) begin n_mismatch++; stop_test; end
    endtask

    // One full polled conversion with the given config and input level
    task automatic conv(input logic [7:0] cfg, input logic [9:0] lv);
        int k;
        level <= lv;
        wr(acc_pkg::OFF_CFG1, cfg);
        @(posedge aclk);
        #1;
        chk("ref_pos", cfg[1:0] == 3 ? 4 : cfg[1:0] == 2 ? 2 : 1,
            ref_pos_onehot);
        chk("ref_neg", cfg[2], ref_neg_pin);
        wr(acc_pkg::OFF_CTRL0, 8'h0D);
        wr(acc_pkg::OFF_CTRL0, 8'h0F);
        rd(acc_pkg::OFF_CTRL0);
        chk("go busy", 1, rv[1]);
        for (k = 0; k < 600 && rv[1] !== 0; k++) rd(acc_pkg::OFF_CTRL0);
        chk("go idle", 0, rv[1]);
        if (rv[1] !== 1'b0) stop_test;
        rd(acc_pkg::OFF_RES_HI);
        chk("res_hi", cfg[7] ? {6'h00, lv[9:8]} : lv[9:2], rv);
        rd(acc_pkg::OFF_RES_LO);
        chk("res_lo", cfg[7] ? lv[7:0] : {lv[1:0], 6'h00},
            rv);
        rd(acc_pkg::OFF_STATUS);
        chk("done", 1, rv);
        wr(acc_pkg::OFF_STATUS, 8'h01);
        rd(acc_pkg::OFF_STATUS);
        chk("done clr", 0, rv);
    endtask

    initial begin
        repeat (100000) @(posedge aclk);
        n_mismatch++;
        stop_test;
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rd(acc_pkg::OFF_CTRL0);
        chk("ctrl0 rst", 0, rv);
        rd(acc_pkg::OFF_CFG1);
        chk("cfg1 rst", 0, rv);
        wr(acc_pkg::OFF_CFG1, 8'hFF);
        rd(acc_pkg::OFF_CFG1);
        chk("cfg1", 8'hF7, rv);
        wr(acc_pkg::OFF_CTRL0, 8'h80);
        rd(acc_pkg::OFF_CTRL0);
        chk("ctrl0", 0, rv);
        rd(8'h20);
        chk("rresp", acc_pkg::RESP_SLVERR, rr);
        chk("rdata unmapped", 0, rv);
        wr(8'h20, 8'hFF);
        chk("bresp", acc_pkg::RESP_SLVERR, rr);
        for (int c = 0; c < 32; c++) begin
            wr(acc_pkg::OFF_CTRL0, {1'b0, 5'(c), 2'b01});
            @(posedge aclk);
            #1;
            chk("chan_code", c, chan_code);
            chk("chan_connect", c < 14 || c > 28,
                chan_connect);
            chk("on pin", 1, conv_enable);
        end
        for (int i = 0; i < 8; i++) begin
            conv({i[0], i[2:0], 1'b0, i[1], i[1:0]},
                 10'h2A5 ^ 10'(i * 81));
        end
        // Abort while still sampling: nothing decided, so the result is zero
        wr(acc_pkg::OFF_CTRL0, 8'h0F);
        wr(acc_pkg::OFF_CTRL0, 8'h0D);
        rd(acc_pkg::OFF_RES_LO);
        chk("abort res_lo", 0, rv);
        rd(acc_pkg::OFF_CTRL0);
        chk("abort go", 0, rv[1]);
        rd(acc_pkg::OFF_STATUS);
        chk("abort done", 0, rv);
        // Trigger while idle and enabled; period choice is ours
        @(posedge aclk);
        special_event_trigger <= 1;
        @(posedge aclk);
        special_event_trigger <= 0;
        #1;
        chk("timer_rst", 1, timer_one_reset);
        rd(acc_pkg::OFF_CTRL0);
        chk("go trig", 1, rv[1]);
        stop_test;
    end
endmodule // tb_top
